// file: adc_ctrl.sv
/*
 * Converter control end: control/status and trigger control registers,
 * channel sequencing, timing of conversions, result storage with the
 * lower-byte holding latch.
 * Assumes a SAR core that takes a start pulse and channel, and answers
 * with a done strobe and a 10-bit value; bus inputs synchronous to mclk.
 */
`timescale 1ns/10ps
module adc_ctrl
    import adc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic standby,
    adc_bus_if.device bus,
    input wire logic external_trigger_pin_n,
    output logic sar_start,
    output logic [2:0] sar_channel,
    input wire logic sar_done,
    input wire logic [9:0] sar_value
);
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT} adc_state_t;

    logic [7:0] csr_reg, csr_next;
    logic trg_en_reg, trg_en_next;
    logic trg_prev_reg, trg_prev_next;
    logic done_seen_reg, done_seen_next;
    logic [9:0] res_reg [4];
    logic [9:0] res_next [4];
    logic [7:0] hold_reg, hold_next;
    logic [1:0] chan_reg, chan_next;
    logic first_reg, first_next;
    logic [8:0] cnt_reg, cnt_next;
    logic [7:0] rdata_reg, rdata_next;
    adc_state_t state_reg, state_next;

    logic wr_csr, rd_csr, trig_fire, sw_start, sw_halt;
    logic [1:0] rsel;
    assign wr_csr = bus.sel && bus.wr && bus.addr == OFS_CTRL_STATUS;
    assign rd_csr = bus.sel && !bus.wr && bus.addr == OFS_CTRL_STATUS;
    assign trig_fire = trg_en_reg && trg_prev_reg
        && !external_trigger_pin_n;
    assign sw_start = wr_csr && bus.wdata[BIT_RUN];
    assign sw_halt = wr_csr && !bus.wdata[BIT_RUN];
    assign rsel = bus.addr[2:1];
    assign bus.conversion_end_request = csr_reg[BIT_DONE]
        && csr_reg[BIT_IRQ_EN];
    assign bus.rdata = rdata_reg;

    always_comb begin
        logic [8:0] len;
        len = '0;
        csr_next = csr_reg;
        trg_en_next = trg_en_reg;
        trg_prev_next = external_trigger_pin_n;
        done_seen_next = done_seen_reg;
        res_next = res_reg;
        hold_next = hold_reg;
        chan_next = chan_reg;
        first_next = first_reg;
        cnt_next = cnt_reg;
        state_next = state_reg;
        rdata_next = 8'h00;
        sar_start = 1'b0;
        sar_channel = {csr_reg[BIT_GROUP], chan_reg};
        // Register writes; done bit cleared here or by a DMA access
        if (wr_csr) begin
            csr_next[6:0] = bus.wdata[6:0];
            if (!bus.wdata[BIT_DONE] && done_seen_reg) begin
                csr_next[BIT_DONE] = 1'b0;
                done_seen_next = 1'b0;
            end
        end
        if (rd_csr && csr_reg[BIT_DONE])
            done_seen_next = 1'b1;
        if (bus.sel && bus.dma_access) begin
            csr_next[BIT_DONE] = 1'b0;
            done_seen_next = 1'b0;
        end
        if (bus.sel && bus.wr && bus.addr == OFS_TRIG_CTRL)
            trg_en_next = bus.wdata[BIT_TRIG_EN];
        // Reads; data registered for a steady output
        if (bus.sel && !bus.wr) begin
            case (bus.addr)
                OFS_CTRL_STATUS: rdata_next = csr_reg;
                OFS_TRIG_CTRL:
                    rdata_next = {trg_en_reg, TRIG_RESERVED_ONES};
                default: begin
                    if (bus.addr[3] == OFS_RES0_HI[3]) begin
                        if (bus.addr[0] == OFS_RES0_LO[0]) begin
                            rdata_next = hold_reg;
                        end else begin
                            rdata_next = res_reg[rsel][9:2];
                            hold_next = {res_reg[rsel][1:0], 6'h00};
                        end
                    end
                end
            endcase
        end
        if (trig_fire)
            csr_next[BIT_RUN] = 1'b1;
        if (csr_reg[BIT_TIME_SEL])
            len = first_reg ? 9'(FIRST_CONV_FAST) : 9'(NEXT_CONV_FAST);
        else
            len = first_reg ? 9'(FIRST_CONV_SLOW) : 9'(NEXT_CONV_SLOW);
        case (state_reg)
            ST_IDLE: begin
                if (sw_start || trig_fire || csr_reg[BIT_RUN]) begin
                    chan_next = csr_reg[BIT_SCAN] || sw_start
                        ? 2'd0 : csr_reg[1:0];
                    if (sw_start)
                        chan_next = bus.wdata[BIT_SCAN]
                            ? 2'd0 : bus.wdata[1:0];
                    first_next = 1'b1;
                    cnt_next = 9'd1;
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                sar_start = cnt_reg == 9'd1;
                cnt_next = cnt_reg + 9'd1;
                if (cnt_reg >= len - 9'd1)
                    state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (sar_done) begin
                    res_next[chan_reg] = sar_value;
                    cnt_next = 9'd1;
                    first_next = 1'b0;
                    if (!csr_reg[BIT_SCAN]) begin
                        csr_next[BIT_DONE] = 1'b1;
                        csr_next[BIT_RUN] = 1'b0;
                        state_next = ST_IDLE;
                    end else if (chan_reg == csr_reg[1:0]) begin
                        csr_next[BIT_DONE] = 1'b1;
                        chan_next = 2'd0;
                        state_next = ST_CONV;
                    end else begin
                        chan_next = chan_reg + 2'd1;
                        state_next = ST_CONV;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Halt wins over sequencing unless the trigger fires in that cycle; a halted sweep restarts at input 0
        if (sw_halt && state_reg != ST_IDLE && !trig_fire) begin
            csr_next[BIT_RUN] = 1'b0;
            state_next = ST_IDLE;
        end
        if (state_reg == ST_IDLE && csr_next[BIT_RUN] == 1'b0)
            state_next = ST_IDLE;
    end

    always_ff @(posedge mclk) begin
        if (rst || standby) begin
            csr_reg <= CTRL_STATUS_RESET;
            trg_en_reg <= TRIG_CTRL_RESET[BIT_TRIG_EN];
            trg_prev_reg <= 1'b1;
            done_seen_reg <= 1'b0;
            for (int i = 0; i < 4; i++)
                res_reg[i] <= 10'h000;
            hold_reg <= 8'h00;
            chan_reg <= 2'd0;
            first_reg <= 1'b1;
            cnt_reg <= 9'd0;
            rdata_reg <= 8'h00;
            state_reg <= ST_IDLE;
        end else begin
            csr_reg <= csr_next;
            trg_en_reg <= trg_en_next;
            trg_prev_reg <= trg_prev_next;
            done_seen_reg <= done_seen_next;
            res_reg <= res_next;
            hold_reg <= hold_next;
            chan_reg <= chan_next;
            first_reg <= first_next;
            cnt_reg <= cnt_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
        end
    end
endmodule // adc_ctrl

// file: adc_pkg.sv
/*
 * Package for the converter control block: register offsets, field
 * positions, reset values and conversion timing counts.
 * Assumes an 8-bit peripheral bus with byte offsets from the block base.
 */
package adc_pkg;
    localparam logic [3:0] OFS_RES0_HI = 4'h0;
    localparam logic [3:0] OFS_RES0_LO = 4'h1;
    localparam logic [3:0] OFS_CTRL_STATUS = 4'h8;
    localparam logic [3:0] OFS_TRIG_CTRL = 4'h9;
    localparam int BIT_DONE = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_RUN = 5;
    localparam int BIT_SCAN = 4;
    localparam int BIT_TIME_SEL = 3;
    localparam int BIT_GROUP = 2;
    localparam int BIT_TRIG_EN = 7;
    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
    localparam logic [7:0] TRIG_CTRL_RESET = 8'h7f;
    localparam logic [6:0] TRIG_RESERVED_ONES = 7'h7f;
    // Conversion lengths, in system clocks
    localparam int FIRST_CONV_SLOW = 266;
    localparam int FIRST_CONV_FAST = 134;
    localparam int NEXT_CONV_SLOW = 256;
    localparam int NEXT_CONV_FAST = 128;
endpackage

// file: adc_bus_if.sv
/*
 * Interface joining the peripheral-bus master end and the converter
 * control end. Single-cycle 8-bit accesses, answer in the next cycle.
 */
`timescale 1ns/10ps
interface adc_bus_if;
    logic sel;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic dma_access;
    logic conversion_end_request;
    modport device (
        input sel,
        input wr,
        input addr,
        input wdata,
        input dma_access,
        output rdata,
        output conversion_end_request
    );
    modport host (
        output sel,
        output wr,
        output addr,
        output wdata,
        output dma_access,
        input rdata,
        input conversion_end_request
    );
endinterface

// file: adc_host.sv
/*
 * Bus master end: turns single user requests into one-cycle register
 * accesses, and a word read into an upper then lower byte read.
 * Assumes the device answers read data one cycle after the access.
 */
`timescale 1ns/10ps
module adc_host
    import adc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    adc_bus_if.host bus,
    input wire logic req,
    input wire logic req_wr,
    input wire logic req_word,
    input wire logic req_dma,
    input wire logic [3:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic busy,
    output logic [15:0] rsp_data,
    output logic rsp_valid,
    output logic irq
);
    typedef enum logic [1:0] {HS_IDLE, HS_HI, HS_LO, HS_DONE} adch_state_t;
    adch_state_t state_reg, state_next;
    logic [3:0] addr_reg, addr_next;
    logic word_reg, word_next;
    logic [15:0] data_reg, data_next;
    logic valid_reg, valid_next;

    assign busy = state_reg != HS_IDLE;
    assign rsp_data = data_reg;
    assign rsp_valid = valid_reg;
    assign irq = bus.conversion_end_request;
    assign bus.wdata = req_wdata;
    assign bus.dma_access = req_dma && state_reg == HS_IDLE;

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        word_next = word_reg;
        data_next = data_reg;
        valid_next = 1'b0;
        bus.sel = 1'b0;
        bus.wr = 1'b0;
        bus.addr = addr_reg;
        case (state_reg)
            HS_IDLE: begin
                bus.addr = req_addr;
                if (req) begin
                    bus.sel = 1'b1;
                    bus.wr = req_wr;
                    // Word reads start at the upper byte
                    addr_next = req_addr;
                    word_next = req_word;
                    if (!req_wr)
                        state_next = HS_HI;
                end
            end
            HS_HI: begin
                data_next = {bus.rdata, 8'h00};
                if (word_reg) begin
                    bus.sel = 1'b1;
                    bus.addr = addr_reg | 4'h1;
                    state_next = HS_LO;
                end else begin
                    data_next = {8'h00, bus.rdata};
                    valid_next = 1'b1;
                    state_next = HS_IDLE;
                end
            end
            HS_LO: begin
                data_next = {data_reg[15:8], bus.rdata};
                valid_next = 1'b1;
                state_next = HS_IDLE;
            end
            default: state_next = HS_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= HS_IDLE;
            addr_reg <= 4'h0;
            word_reg <= 1'b0;
            data_reg <= 16'h0000;
            valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            word_reg <= word_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
        end
    end
endmodule // adc_host

// file: adc_ctrl_sva.sv
/* Bus-side assertions for the converter control block.
   Assumes interface signals on mclk; rdata comes one cycle after sel. */
`timescale 1ns/10ps
module adc_ctrl_sva
    import adc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic standby,
    input wire logic sel,
    input wire logic wr,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic dma_access,
    input wire logic conversion_end_request
);
    localparam int LIM_SLOW = FIRST_CONV_SLOW + 8;
    localparam int LIM_FAST = FIRST_CONV_FAST + 8;
    logic clr, wc, wt, rc;
    logic [7:0] ctrl_w_reg, trig_w_reg;
    logic [8:0] age_reg;
    assign clr = rst || standby;
    assign wc = sel && wr && addr == OFS_CTRL_STATUS;
    assign wt = sel && wr && addr == OFS_TRIG_CTRL;
    assign rc = sel && !wr && addr == OFS_CTRL_STATUS;
    // Last software writes, which later reads must echo
    always_ff @(posedge mclk) begin
        if (clr) begin
            ctrl_w_reg <= CTRL_STATUS_RESET;
            trig_w_reg <= 8'h00;
            age_reg <= 9'h000;
        end else begin
            ctrl_w_reg <= wc ? wdata : ctrl_w_reg;
            trig_w_reg <= wt ? wdata : trig_w_reg;
            age_reg <= wc ? 9'h000 : age_reg + 9'(age_reg != 9'h1ff);
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (clr);
    sequence run_started_s;
        rc && ctrl_w_reg[BIT_RUN] && age_reg < 9'h064;
    endsequence
    // Trigger off, so only the software start can have set the run bit
    sequence single_over_s;
        rc && ctrl_w_reg[BIT_RUN] && !ctrl_w_reg[BIT_SCAN] && !trig_w_reg[7]
        && age_reg > (ctrl_w_reg[BIT_TIME_SEL] ? LIM_FAST : LIM_SLOW);
    endsequence
    trig_ones_a: assert property (
        sel && !wr && addr == OFS_TRIG_CTRL
        |=> rdata == {trig_w_reg[7], 7'h7f})
        else $error("trigger control read mismatch");
    ctrl_echo_a: assert property (
        rc |=> {rdata[6], rdata[4:0]} == {ctrl_w_reg[6], ctrl_w_reg[4:0]})
        else $error("control fields not as written");
    low_zero_a: assert property (
        sel && !wr && addr < 4'h8 && addr[0] |=> rdata[5:0] == 6'h00)
        else $error("result low byte padding not zero");
    irq_flag_a: assert property (
        rc |=> (rdata[7] & rdata[6]) == $past(conversion_end_request))
        else $error("request differs from done and enable");
    dma_clear_a: assert property (
        sel && dma_access |=> !conversion_end_request)
        else $error("request kept after dma access");
    reset_clear_a: assert property (disable iff (1'b0)
        clr |=> !conversion_end_request && rdata == 8'h00)
        else $error("state not cleared by reset");
    run_hold_a: assert property (
        run_started_s |=> rdata[BIT_RUN])
        else $error("run bit low while converting");
    single_end_a: assert property (
        single_over_s |=> !rdata[BIT_RUN])
        else $error("single conversion overran");
endmodule // adc_ctrl_sva

// file: adc_control_and_result_access_tb.sv
/* Testbench: host and control ends joined by the bus interface, a core
   stand-in and a queued response check. Assumes one 100 MHz clock. */
`timescale 1ns/10ps
module adc_control_and_result_access_tb
    import adc_pkg::*;
();
    localparam logic [15:0] ALL = 16'hffff;
    logic mclk = 1'b0;
    logic rst, standby, trig_n, sar_done, sar_start, scan_on;
    logic req, req_wr, req_word, req_dma, busy, rsp_valid, irq;
    logic [2:0] sar_channel, exp_ch, scan_n;
    logic [3:0] req_addr;
    logic [7:0] req_wdata, c;
    logic [9:0] sar_value, nv;
    logic [9:0] model [4];
    logic [15:0] rsp_data, r, e_w, m_w;
    logic [15:0] exp_q [$];
    logic [15:0] msk_q [$];
    int n_errors = 0, n_compared = 0, seed = 32'hd37a;
    int cyc = 0, last = 0, scan_i = 0, gap = 0, gap0 = 0, gap_e = 0;
    adc_bus_if bus ();
    adc_ctrl u_adc_ctrl (.mclk(mclk), .rst(rst), .standby(standby),
        .bus(bus.device), .external_trigger_pin_n(trig_n),
        .sar_start(sar_start), .sar_channel(sar_channel),
        .sar_done(sar_done), .sar_value(sar_value));
    adc_host u_adc_host (.mclk(mclk), .rst(rst), .bus(bus.host), .req(req),
        .req_wr(req_wr), .req_word(req_word), .req_dma(req_dma),
        .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .irq(irq));
    adc_ctrl_sva u_adc_ctrl_sva (.mclk(mclk), .rst(rst), .standby(standby),
        .sel(bus.sel), .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata),
        .rdata(bus.rdata), .dma_access(bus.dma_access),
        .conversion_end_request(bus.conversion_end_request));
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    task automatic chk(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Word reads only: the upper byte always goes first
    task automatic acc(input logic w, d, input logic [3:0] a,
            input logic [7:0] v, input logic [15:0] e, m);
        int i;
        i = 0;
        @(posedge mclk);
        while (busy !== 1'b0 && i < 50) begin
            @(posedge mclk);
            i++;
        end
        {req, req_wr, req_word, req_dma} <= {1'b1, w, !w, d};
        {req_addr, req_wdata} <= {a, w ? v : 8'($random(seed))};
        @(posedge mclk);
        req <= 1'b0;
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
            for (i = 0; rsp_valid !== 1'b1 && i < 50; i++)
                @(posedge mclk);
            r = rsp_data;
        end
        if (i >= 50) begin
            n_errors++;
            results();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        acc(1'b1, 1'b0, a, v, '0, '0);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
        acc(1'b0, 1'b0, a, 8'h00, e, m);
    endtask
    task automatic poll(input int b, input logic v);
        int k;
        k = 0;
        do begin
            rd(OFS_CTRL_STATUS, '0, '0);
            k++;
        end while (r[8 + b] !== v && k < 400);
        if (r[8 + b] !== v) begin
            n_errors++;
            results();
        end
    endtask
    // Core stand-in: done held high, fresh random value per start
    always @(posedge mclk) begin
        if (sar_start === 1'b1) begin
            chk("sar_channel", 16'(exp_ch), 16'(sar_channel));
            // The gap after the first start spans the first conversion
            gap_e = scan_i == 1 ? gap0 : gap;
            if (scan_on && scan_i > 0)
                chk("conv_gap", 16'(gap_e), 16'(cyc - last));
            nv = 10'($random(seed));
            sar_value <= nv;
            model[exp_ch[1:0]] = nv;
            last = cyc;
            scan_i++;
            if (scan_on)
                exp_ch[1:0] = exp_ch[1:0] == scan_n[1:0] ? 2'b00
                    : exp_ch[1:0] + 2'b01;
        end
    end
    always @(posedge mclk) begin
        if (rsp_valid === 1'b1) begin
            e_w = exp_q.pop_front();
            m_w = msk_q.pop_front();
            if (m_w != 16'h0)
                chk("rsp_data", e_w & m_w, rsp_data & m_w);
        end
    end
    initial begin
        {rst, standby, trig_n, sar_done, scan_on} = 5'b10110;
        {req, req_wr, req_word, req_dma, req_addr, req_wdata} = '0;
        {exp_ch, scan_n, sar_value, r} = '0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_CTRL_STATUS, 16'h007f, ALL);
        rd(4'he, '0, ALL);
        wr(OFS_TRIG_CTRL, 8'hff);
        rd(OFS_CTRL_STATUS, 16'h00ff, ALL);
        wr(OFS_TRIG_CTRL, 8'h7f);
        for (int k = 0; k < 8; k++) begin
            c = {1'b0, 1'($random(seed)), 2'b10, 1'($random(seed)), 3'(k)};
            exp_ch = 3'(k);
            wr(OFS_CTRL_STATUS, c);
            poll(BIT_RUN, 1'b0);
            rd(OFS_CTRL_STATUS, {c ^ 8'ha0, 8'h7f}, ALL);
            chk("irq", 16'(c[6]), 16'(irq));
            rd({1'b0, k[1:0], 1'b0}, {model[k[1:0]], 6'h0}, ALL);
            // Latch, not the live low byte of another result
            rd({1'b0, ~k[1:0], 1'b1},
                {2{model[k[1:0]][1:0], 6'h00}}, ALL);
            if (k[0]) begin
                wr(OFS_CTRL_STATUS, c ^ 8'ha0);
                rd(OFS_CTRL_STATUS, {c ^ 8'ha0, 8'h7f}, ALL);
                wr(OFS_CTRL_STATUS, c & 8'h5f);
            end else
                acc(1'b0, 1'b1, OFS_CTRL_STATUS, 8'h00, '0, '0);
            rd(OFS_CTRL_STATUS, {c & 8'h5f, 8'h7f}, ALL);
            chk("irq", '0, 16'(irq));
        end
        for (int j = 0; j < 2; j++) begin
            c = j ? 8'h33 : 8'h3e;
            scan_n = {1'b0, c[1:0]};
            gap = c[3] ? NEXT_CONV_FAST : NEXT_CONV_SLOW;
            gap0 = c[3] ? FIRST_CONV_FAST : FIRST_CONV_SLOW;
            repeat (2) begin
                scan_on = 1'b1;
                scan_i = 0;
                exp_ch = {c[2], 2'b00};
                wr(OFS_CTRL_STATUS, c);
                poll(BIT_DONE, 1'b1);
                chk("sweep", 16'h1, 16'(scan_i > scan_n));
                rd(OFS_CTRL_STATUS, {c | 8'h80, 8'h7f}, ALL);
                wr(OFS_CTRL_STATUS, c & 8'h5f);
                scan_on = 1'b0;
                rd(OFS_CTRL_STATUS, {c & 8'h5f, 8'h7f}, 16'h7fff);
            end
        end
        wr(OFS_CTRL_STATUS, 8'h01);
        exp_ch = 3'h1;
        trig_n <= 1'b0;
        rd(OFS_CTRL_STATUS, 16'h017f, ALL);
        trig_n <= 1'b1;
        wr(OFS_TRIG_CTRL, 8'hff);
        trig_n <= 1'b0;
        poll(BIT_RUN, 1'b1);
        rd(OFS_CTRL_STATUS, 16'h21ff, ALL);
        trig_n <= 1'b1;
        wr(OFS_CTRL_STATUS, 8'h33);
        standby <= 1'b1;
        @(posedge mclk);
        standby <= 1'b0;
        rd(OFS_CTRL_STATUS, 16'h007f, ALL);
        results();
    end
endmodule // adc_control_and_result_access_tb
